// [verilog/rge_pkg.sv]
// Constants, register map and delay table for the rail enable gating block
// Assumes a 100 MHz core clock and a byte-wide register port fed by the serial host
// Overview of operation
// - First rail rise delay from bits 2:0
// - First rail fall delay from bits 5:3
// - Mask bits 7:0 drop step-down/switch/aux flags
// - Mask bits drop first-switch and aux-three flags
// - Threshold code bits 6:5 go to monitor
// - Shared rail source chosen by bits 4:2
// - Registers reset to zero, then load factory values
// - Combine bit drives second switch from first
package rge_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_EDGE_DELAYS = 8'h24;
   localparam logic [7:0] ADDR_GOOD_MASK = 8'h25;
   localparam logic [7:0] ADDR_SRC_THRESH = 8'h26;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int RISE_LSB = 0;
   localparam int FALL_LSB = 3;
   localparam int MASK_FIRST_SWITCH_BIT = 1;
   localparam int MASK_AUX_THREE_BIT = 0;
   localparam int SRC_LSB = 2;
   localparam int THRESH_LSB = 5;

   // ---------------------------------------------------------------
   // Source select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_PIN1 = 3'h0;
   localparam logic [2:0] SRC_PIN2 = 3'h1;
   localparam logic [2:0] SRC_PIN5 = 3'h2;
   localparam logic [2:0] SRC_PIN4 = 3'h3;
   localparam logic [2:0] SRC_PIN3 = 3'h4;
   localparam logic [2:0] SRC_PIN3_AND_4 = 3'h5;
   localparam logic [2:0] SRC_PIN6 = 3'h6;
   localparam logic [2:0] SRC_ALWAYS = 3'h7;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_MS = 1000000 / TICK_NS;
   localparam int DLY_W = 10;

   // Delay code to 100 us ticks
   function automatic logic [DLY_W-1:0] delay_ticks(input logic [2:0] code);
      logic [DLY_W-1:0] ms;
      unique case (code)
         3'h0: ms = 10'h000;
         3'h1: ms = 10'h002;
         3'h2: ms = 10'h004;
         3'h3: ms = 10'h008;
         3'h4: ms = 10'h010;
         3'h5: ms = 10'h018;
         3'h6: ms = 10'h020;
         3'h7: ms = 10'h040;
      endcase
      delay_ticks = DLY_W'(ms * TICKS_PER_MS);
   endfunction

   typedef enum logic [1:0] {
      DLY_LOW = 2'b00,
      DLY_RISE = 2'b01,
      DLY_HIGH = 2'b11,
      DLY_FALL = 2'b10
   } rge_dly_state_t;

endpackage

// [verilog/rge_dly_if.sv]
// Carrier between the gating top and its edge delay unit
// Assumes one clock domain shared by both ends
interface rge_dly_if;
   logic tick;
   logic level_in;
   logic [2:0] rise_code;
   logic [2:0] fall_code;
   logic level_out;
   modport ctrl (output tick, output level_in, output rise_code, output fall_code,
      input level_out);
   modport dly (input tick, input level_in, input rise_code, input fall_code,
      output level_out);
endinterface

// [verilog/rge_edge_delay.sv]
// Programmable rise and fall delay on one enable level
// Assumes a one-cycle tick every 100 us from the top
module rge_edge_delay (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   rge_dly_if.dly d
);

   rge_pkg::rge_dly_state_t state_q, state_d;
   logic [rge_pkg::DLY_W-1:0] cnt_q, cnt_d;
   logic [rge_pkg::DLY_W-1:0] rise_tgt, fall_tgt, cnt_inc;

   assign rise_tgt = rge_pkg::delay_ticks(d.rise_code);
   assign fall_tgt = rge_pkg::delay_ticks(d.fall_code);
   assign cnt_inc = cnt_q + 10'h001;
   assign d.level_out = state_q[1];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         rge_pkg::DLY_LOW: begin
            cnt_d = '0;
            if (d.level_in) begin
               state_d = (rise_tgt == '0) ? rge_pkg::DLY_HIGH : rge_pkg::DLY_RISE;
            end
         end
         rge_pkg::DLY_RISE: begin
            if (!d.level_in) begin
               state_d = rge_pkg::DLY_LOW;
            end else if (d.tick) begin
               cnt_d = cnt_inc;
               if (cnt_inc >= rise_tgt) begin
                  state_d = rge_pkg::DLY_HIGH;
               end
            end
         end
         rge_pkg::DLY_HIGH: begin
            cnt_d = '0;
            if (!d.level_in) begin
               state_d = (fall_tgt == '0) ? rge_pkg::DLY_LOW : rge_pkg::DLY_FALL;
            end
         end
         rge_pkg::DLY_FALL: begin
            if (d.level_in) begin
               state_d = rge_pkg::DLY_HIGH;
            end else if (d.tick) begin
               cnt_d = cnt_inc;
               if (cnt_inc >= fall_tgt) begin
                  state_d = rge_pkg::DLY_LOW;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= rge_pkg::DLY_LOW;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

endmodule

// [verilog/rge_rail_enable_gating.sv]
// Enable gating for the first switch rail and the shared switch/regulator rail
// Assumes synchronous control pins and power-good flags, and a byte register port
module rge_rail_enable_gating #(
   parameter int unsigned TICK_CYCLES = rge_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] factory_edge_delays_i,
   input wire logic [7:0] factory_good_mask_i,
   input wire logic [7:0] factory_src_thresh_i,
   input wire logic [5:0] control_input_i,
   input wire logic switch_b_one_gate_i,
   input wire logic [9:0] power_good_flag_i,
   input wire logic combine_switch_enables_i,
   output logic switch_b_one_en_o,
   output logic switch_b_two_en_o,
   output logic shared_switch_regulator_rail_en_o,
   output logic [1:0] shared_rail_good_threshold_o
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic load_pend_q, load_pend_d;
   logic [7:0] edge_delays_q, edge_delays_d;
   logic [7:0] good_mask_q, good_mask_d;
   logic [7:0] src_thresh_q, src_thresh_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      load_pend_d = 1'b0;
      edge_delays_d = edge_delays_q;
      good_mask_d = good_mask_q;
      src_thresh_d = src_thresh_q;
      rdata_d = rdata_q;
      if (load_pend_q) begin
         edge_delays_d = factory_edge_delays_i;
         good_mask_d = factory_good_mask_i;
         src_thresh_d = factory_src_thresh_i;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            rge_pkg::ADDR_EDGE_DELAYS: edge_delays_d = reg_wdata_i;
            rge_pkg::ADDR_GOOD_MASK: good_mask_d = reg_wdata_i;
            rge_pkg::ADDR_SRC_THRESH: src_thresh_d = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            rge_pkg::ADDR_EDGE_DELAYS: rdata_d = edge_delays_q;
            rge_pkg::ADDR_GOOD_MASK: rdata_d = good_mask_q;
            rge_pkg::ADDR_SRC_THRESH: rdata_d = src_thresh_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         load_pend_q <= 1'b1;
         edge_delays_q <= 8'h00;
         good_mask_q <= 8'h00;
         src_thresh_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         load_pend_q <= load_pend_d;
         edge_delays_q <= edge_delays_d;
         good_mask_q <= good_mask_d;
         src_thresh_q <= src_thresh_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Timebase
   // ---------------------------------------------------------------
   logic [31:0] div_q, div_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 32'h00000001;
      if (div_q >= 32'(TICK_CYCLES - 1)) begin
         div_d = 32'h00000000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   // ---------------------------------------------------------------
   // First switch rail delay
   // ---------------------------------------------------------------
   rge_dly_if dly_bus ();
   assign dly_bus.tick = tick_q;
   // Gate held off until the start values are loaded
   assign dly_bus.level_in = switch_b_one_gate_i & ~load_pend_q;
   assign dly_bus.rise_code = edge_delays_q[rge_pkg::RISE_LSB +: 3];
   assign dly_bus.fall_code = edge_delays_q[rge_pkg::FALL_LSB +: 3];

   rge_edge_delay u_first_dly (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d(dly_bus.dly)
   );

   // ---------------------------------------------------------------
   // Shared rail gating
   // ---------------------------------------------------------------
   logic [2:0] src_sel;
   logic src_level;
   logic [9:0] mask_all;
   logic good_ok;

   assign src_sel = src_thresh_q[rge_pkg::SRC_LSB +: 3];
   assign mask_all = {src_thresh_q[rge_pkg::MASK_FIRST_SWITCH_BIT],
      src_thresh_q[rge_pkg::MASK_AUX_THREE_BIT], good_mask_q};
   assign good_ok = &(power_good_flag_i | mask_all);

   always_comb begin
      unique case (src_sel)
         rge_pkg::SRC_PIN1: src_level = control_input_i[0];
         rge_pkg::SRC_PIN2: src_level = control_input_i[1];
         rge_pkg::SRC_PIN5: src_level = control_input_i[4];
         rge_pkg::SRC_PIN4: src_level = control_input_i[3];
         rge_pkg::SRC_PIN3: src_level = control_input_i[2];
         rge_pkg::SRC_PIN3_AND_4: src_level = control_input_i[2] & control_input_i[3];
         rge_pkg::SRC_PIN6: src_level = control_input_i[5];
         rge_pkg::SRC_ALWAYS: src_level = 1'b1;
      endcase
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic first_en_d, second_en_d, shared_en_d;
   logic [1:0] thresh_d;

   always_comb begin
      first_en_d = dly_bus.level_out;
      shared_en_d = src_level & good_ok;
      second_en_d = combine_switch_enables_i ? dly_bus.level_out : shared_en_d;
      thresh_d = src_thresh_q[rge_pkg::THRESH_LSB +: 2];
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         switch_b_one_en_o <= 1'b0;
         switch_b_two_en_o <= 1'b0;
         shared_switch_regulator_rail_en_o <= 1'b0;
         shared_rail_good_threshold_o <= 2'h0;
      end else begin
         switch_b_one_en_o <= first_en_d;
         switch_b_two_en_o <= second_en_d;
         shared_switch_regulator_rail_en_o <= shared_en_d;
         shared_rail_good_threshold_o <= thresh_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   rise_immediate_a: assert property (
      !dly_bus.level_out && dly_bus.level_in && dly_bus.rise_code == 3'h0
      |=> ##1 switch_b_one_en_o)
      else $error("Zero rise delay did not enable at once");
   rise_hold_a: assert property (
      !dly_bus.level_out && dly_bus.rise_code != 3'h0 && $rose(dly_bus.level_in)
      |=> !dly_bus.level_out [*8])
      else $error("Rise delay ended too early");
   fall_immediate_a: assert property (
      dly_bus.level_out && !dly_bus.level_in && dly_bus.fall_code == 3'h0
      |=> ##1 !switch_b_one_en_o)
      else $error("Zero fall delay did not disable at once");
   fall_hold_a: assert property (
      dly_bus.level_out && dly_bus.fall_code != 3'h0 && $fell(dly_bus.level_in)
      |=> dly_bus.level_out [*8])
      else $error("Fall delay ended too early");
   low_mask_a: assert property (
      |(~power_good_flag_i[7:0] & ~good_mask_q) |=> !shared_switch_regulator_rail_en_o)
      else $error("Unmasked low flag did not block shared rail");
   high_mask_a: assert property (
      |(~power_good_flag_i[9:8] & ~mask_all[9:8]) |=> !shared_switch_regulator_rail_en_o)
      else $error("Unmasked first switch or aux three flag ignored");
   thresh_pass_a: assert property (
      ##1 shared_rail_good_threshold_o == $past(src_thresh_q[6:5]))
      else $error("Threshold code not passed on");
   force_high_a: assert property (
      src_sel == rge_pkg::SRC_ALWAYS && good_ok |=> shared_switch_regulator_rail_en_o)
      else $error("Forced source did not enable");
   factory_load_a: assert property (
      $fell(load_pend_q) |-> edge_delays_q == $past(factory_edge_delays_i)
      && good_mask_q == $past(factory_good_mask_i)
      && src_thresh_q == $past(factory_src_thresh_i))
      else $error("Factory value not loaded");
   combine_a: assert property (
      combine_switch_enables_i |=> switch_b_two_en_o == switch_b_one_en_o)
      else $error("Combined enables differ");
   source_low_a: assert property (
      !src_level |=> !shared_switch_regulator_rail_en_o)
      else $error("Shared rail on without source");

   rise_seen_c: cover property ($rose(switch_b_one_en_o));
   fall_seen_c: cover property ($fell(switch_b_one_en_o));
   shared_on_c: cover property ($rose(shared_switch_regulator_rail_en_o));
   combine_on_c: cover property (combine_switch_enables_i && switch_b_two_en_o);

endmodule

// [verif/rge_ctrl_model.sv]
// Behavioural system controller that drives the control pins
// Assumes bench requests sampled on the shared core clock
module rge_ctrl_model (
   input wire logic core_clk_i,
   input wire logic [5:0] pins_req_i,
   input wire logic gate_req_i,
   input wire logic comb_req_i,
   output logic [5:0] control_input_o,
   output logic switch_b_one_gate_o,
   output logic combine_switch_enables_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      control_input_o = 6'h00;
      switch_b_one_gate_o = 1'b0;
      combine_switch_enables_o = 1'b0;
   end
   // Pins change just after an edge and hold as levels
   always @(posedge core_clk_i) begin
      control_input_o <= pins_req_i;
      switch_b_one_gate_o <= gate_req_i;
      combine_switch_enables_o <= comb_req_i;
   end
endmodule

// [verif/rge_rail_enable_gating_test.sv]
// Self-checking bench for the rail enable gating block
// Assumes the control pin model and a short tick for simulation
module rge_rail_enable_gating_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 4;
   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] cfg;
      logic [5:0] pins;
      logic [9:0] pg;
      logic en;
   } rge_row_t;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [5:0] pins_req = 6'h00;
   logic gate_req = 1'b0;
   logic comb_req = 1'b0;
   logic [9:0] pg = 10'h3ff;
   logic [7:0] rdata;
   logic [5:0] pins;
   logic gate;
   logic comb;
   logic en1;
   logic en2;
   logic ens;
   logic [1:0] thr;
   int fail_count = 0;
   int compares = 0;
   int n;
   int ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
   rge_row_t rows [16] = '{
      {8'h00, 8'h00, 6'h01, 10'h3ff, 1'b1}, {8'h00, 8'h24, 6'h01, 10'h3ff, 1'b0},
      {8'h00, 8'h48, 6'h10, 10'h3ff, 1'b1}, {8'h00, 8'h6c, 6'h08, 10'h3ff, 1'b1},
      {8'h00, 8'h10, 6'h04, 10'h3ff, 1'b1}, {8'h00, 8'h14, 6'h04, 10'h3ff, 1'b0},
      {8'h00, 8'h14, 6'h0c, 10'h3ff, 1'b1}, {8'h00, 8'h18, 6'h20, 10'h3ff, 1'b1},
      {8'h00, 8'h1c, 6'h00, 10'h3ff, 1'b1}, {8'h00, 8'h1c, 6'h3f, 10'h3f7, 1'b0},
      {8'h08, 8'h1c, 6'h3f, 10'h3f7, 1'b1}, {8'h80, 8'h1c, 6'h3f, 10'h37f, 1'b1},
      {8'h00, 8'h1c, 6'h3f, 10'h2ff, 1'b0}, {8'h00, 8'h1d, 6'h3f, 10'h2ff, 1'b1},
      {8'h00, 8'h1d, 6'h3f, 10'h1ff, 1'b0}, {8'h00, 8'h1e, 6'h3f, 10'h1ff, 1'b1}};

   // ---------------------------------------------------------------
   // Clock, model and design
   // ---------------------------------------------------------------
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   rge_ctrl_model ctl (.core_clk_i(core_clk_i), .pins_req_i(pins_req), .gate_req_i(gate_req),
      .comb_req_i(comb_req), .control_input_o(pins), .switch_b_one_gate_o(gate),
      .combine_switch_enables_o(comb));
   rge_rail_enable_gating #(.TICK_CYCLES(T)) uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .factory_edge_delays_i(8'h09), .factory_good_mask_i(8'ha5),
      .factory_src_thresh_i(8'h5c), .control_input_i(pins), .switch_b_one_gate_i(gate),
      .power_good_flag_i(pg), .combine_switch_enables_i(comb), .switch_b_one_en_o(en1),
      .switch_b_two_en_o(en2), .shared_switch_regulator_rail_en_o(ens),
      .shared_rail_good_threshold_o(thr));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      @(negedge core_clk_i);
      chk("read data", {2'b00, exp}, {2'b00, rdata});
   endtask
   task automatic do_reset();
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      @(negedge core_clk_i);
      chk("outputs in reset", 10'h000, {5'h00, en1, en2, ens, thr});
      chk("read data in reset", 10'h000, {2'b00, rdata});
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rd_chk(8'h24, 8'h09);
      rd_chk(8'h25, 8'ha5);
      rd_chk(8'h26, 8'h5c);
      chk("start threshold", 10'h002, {8'h00, thr});
      $display("reset test done");
   endtask
   task automatic edge_time(input logic lvl, input int code);
      int lo;
      int hi;
      lo = ms[code] * rge_pkg::TICKS_PER_MS * T - T;
      hi = ms[code] * rge_pkg::TICKS_PER_MS * T + 6;
      @(posedge core_clk_i);
      gate_req <= lvl;
      n = 0;
      while (en1 !== lvl && n < 3000) begin
         @(negedge core_clk_i);
         n++;
      end
      chk("edge delay in range", 10'h001, {9'h000, n >= lo && n <= hi});
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge core_clk_i);
      fail_count++;
      $display("ERROR watchdog expected finish seen timeout");
      tally_and_finish();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr_reg(8'h25, rows[i].mask);
         wr_reg(8'h26, rows[i].cfg);
         @(posedge core_clk_i);
         pins_req <= rows[i].pins;
         pg <= rows[i].pg;
         repeat (4) @(posedge core_clk_i);
         @(negedge core_clk_i);
         chk("shared enable", {9'h000, rows[i].en}, {9'h000, ens});
         chk("second switch", {9'h000, rows[i].en}, {9'h000, en2});
         chk("threshold", {8'h00, rows[i].cfg[6:5]}, {8'h00, thr});
         rd_chk(8'h25, rows[i].mask);
         rd_chk(8'h26, rows[i].cfg);
      end
      $display("table test done");
      wr_reg(8'h24, 8'hc0);
      rd_chk(8'h24, 8'hc0);
      wr_reg(8'h27, 8'hff);
      rd_chk(8'h27, 8'h00);
      rd_chk(8'h26, 8'h1e);
      $display("register test done");
      for (int c = 0; c < 8; c++) begin
         wr_reg(8'h24, {2'b00, 3'(7 - c), 3'(c)});
         edge_time(1'b1, c);
         edge_time(1'b0, 7 - c);
      end
      $display("delay test done");
      wr_reg(8'h24, 8'h01);
      @(posedge core_clk_i);
      gate_req <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      gate_req <= 1'b0;
      n = 0;
      repeat (120) begin
         @(negedge core_clk_i);
         if (en1 !== 1'b0) n++;
      end
      chk("short gate pulse", 10'h000, 10'(n));
      $display("glitch test done");
      wr_reg(8'h24, 8'h00);
      wr_reg(8'h26, 8'h04);
      @(posedge core_clk_i);
      pins_req <= 6'h00;
      pg <= 10'h3ff;
      comb_req <= 1'b1;
      gate_req <= 1'b1;
      repeat (10) @(negedge core_clk_i);
      chk("combined second switch", 10'h001, {9'h000, en2});
      chk("shared enable held low", 10'h000, {9'h000, ens});
      @(posedge core_clk_i);
      comb_req <= 1'b0;
      repeat (6) @(negedge core_clk_i);
      chk("separate second switch", 10'h000, {9'h000, en2});
      $display("combine test done");
      do_reset();
      tally_and_finish();
   end
endmodule
